/* core/vft_pkg.sv */
/*
  vft_pkg: register map, field layout, timing reference codes and raster
  figures for the video format and word framing block.
  assumes: used by name only (vft_pkg::name), never imported.
*/
package vft_pkg;

  // ----------------------------------------------------------------------
  // register map (index times four gives the byte address)
  // ----------------------------------------------------------------------
  localparam logic [7:0] VFT_CTRL_IDX  = 8'h0b;             // format force + framing
  localparam logic [7:0] VFT_STAT_IDX  = 8'h0c;             // detected format status
  localparam logic [7:0] VFT_CTRL_ADDR = {VFT_CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] VFT_STAT_ADDR = {VFT_STAT_IDX[5:0], 2'b00};
  localparam int         VFT_REG_W     = 10;                // register width

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int VFT_FMT_LSB   = 0;                         // 5-bit format code
  localparam int VFT_FMT_W     = 5;
  localparam int VFT_HD_BIT    = 5;                         // high rate family lock
  localparam int VFT_SD_BIT    = 6;                         // standard rate family lock
  localparam int VFT_STYLE_BIT = 7;                         // framing style
  localparam int VFT_RLGN_BIT  = 8;                         // realign permit
  localparam logic [9:0] VFT_CTRL_RST = 10'h080;            // framing style set

  // ----------------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------------
  localparam int VFT_H_BIT    = 5;
  localparam int VFT_V_BIT    = 6;
  localparam int VFT_F_BIT    = 7;
  localparam int VFT_NSP_BIT  = 8;
  localparam int VFT_LOCK_BIT = 9;

  // ----------------------------------------------------------------------
  // timing reference sequence
  // ----------------------------------------------------------------------
  localparam logic [9:0] VFT_TRS_ONES  = 10'h3ff;
  localparam logic [9:0] VFT_TRS_ZEROS = 10'h000;
  localparam int VFT_TW_H   = 6;                            // timing word bits
  localparam int VFT_TW_V   = 7;
  localparam int VFT_TW_F   = 8;
  localparam int VFT_TW_ONE = 9;                            // always one
  localparam int VFT_FMT_HD_BIT  = 4;                       // code bit: HD family
  localparam int VFT_FMT_625_BIT = 3;                       // code bit: 625 family

  // ----------------------------------------------------------------------
  // format codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] VFT_F_NONE   = 5'h00;
  localparam logic [4:0] VFT_F_525_54 = 5'h01;
  localparam logic [4:0] VFT_F_525_36 = 5'h02;
  localparam logic [4:0] VFT_F_525_27 = 5'h03;
  localparam logic [4:0] VFT_F_625_54 = 5'h09;
  localparam logic [4:0] VFT_F_625_36 = 5'h0a;
  localparam logic [4:0] VFT_F_625_27 = 5'h0b;
  localparam logic [4:0] VFT_F_1035I  = 5'h11;
  localparam logic [4:0] VFT_F_1080I30 = 5'h12;
  localparam logic [4:0] VFT_F_1080P30 = 5'h13;
  localparam logic [4:0] VFT_F_1080I25 = 5'h19;
  localparam logic [4:0] VFT_F_1080P25 = 5'h1a;
  localparam logic [4:0] VFT_F_1250I25 = 5'h1c;
  localparam logic [4:0] VFT_F_1080P24 = 5'h1d;
  localparam logic [4:0] VFT_F_720P60  = 5'h14;

  // ----------------------------------------------------------------------
  // raster figures: total lines, words per line, active lines
  // ----------------------------------------------------------------------
  localparam logic [11:0] VFT_L525  = 12'h20d;
  localparam logic [11:0] VFT_L625  = 12'h271;
  localparam logic [11:0] VFT_L1125 = 12'h465;
  localparam logic [11:0] VFT_L1250 = 12'h4e2;
  localparam logic [11:0] VFT_L750  = 12'h2ee;
  localparam logic [11:0] VFT_S3432 = 12'hd68;
  localparam logic [11:0] VFT_S2288 = 12'h8f0;
  localparam logic [11:0] VFT_S1716 = 12'h6b4;
  localparam logic [11:0] VFT_S3456 = 12'hd80;
  localparam logic [11:0] VFT_S2304 = 12'h900;
  localparam logic [11:0] VFT_S1728 = 12'h6c0;
  localparam logic [11:0] VFT_S2200 = 12'h898;
  localparam logic [11:0] VFT_S2640 = 12'ha50;
  localparam logic [11:0] VFT_S2376 = 12'h948;
  localparam logic [11:0] VFT_S2750 = 12'habe;
  localparam logic [11:0] VFT_S1650 = 12'h672;
  localparam logic [11:0] VFT_A1035 = 12'h40b;

  // framing state, one-hot
  typedef enum logic [1:0] {
    VFT_FRM_HUNT = 2'b01,
    VFT_FRM_LOCK = 2'b10
  } vft_frm_e;

endpackage

/* core/vft_trs_if.sv */
/*
  vft_trs_if: carries the sequence search result and the chosen word
  boundary between the framing controller and the bit aligner.
  assumes: both ends on the same word clock.
*/
`timescale 1ns/1ns
interface vft_trs_if;
  logic       hit;        // sequence found this cycle
  logic [3:0] hit_off;    // bit offset of that sequence
  logic [9:0] tword;      // its timing word
  logic [3:0] align;      // word boundary in use
  logic [9:0] word;       // realigned output word

  modport aligner (output hit, output hit_off, output tword, output word, input align);
  modport ctrl    (input hit, input hit_off, input tword, input word, output align);
endinterface

/* core/vft_trs_align.sv */
/*
  vft_trs_align: bit history of the raw word stream, search for the
  3ff/000/000 sequence at every bit offset, and word realignment.
  assumes: raw words arrive on the word clock, one per edge, oldest bit
  in the upper end of each word.
*/
`timescale 1ns/1ns
module vft_trs_align #(
  parameter int W = 10                          // word width
) (
  input  wire logic     clock,
  input  wire logic     resetn,
  input  wire logic [W-1:0] raw_word,
  vft_trs_if.aligner    trs
);

  // ----------------------------------------------------------------------
  // history: five words cover any offset plus the timing word
  // ----------------------------------------------------------------------
  logic [5*W-1:0] hist_r;                       // newest word in low bits
  logic [W-1:0]   hits;                         // one flag per offset
  logic [3:0]     off_nxt;                      // lowest offset hit

  // shift in one raw word per cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hist_r <= '0;
    end else begin
      hist_r <= {hist_r[4*W-1:0], raw_word};
    end
  end

  // sequence match
  // each offset looks for ones, zeros, zeros, then a timing word with msb set
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_off
      assign hits[g] = (hist_r[g+4*W-1 -: W] == vft_pkg::VFT_TRS_ONES)
                     && (hist_r[g+3*W-1 -: W] == vft_pkg::VFT_TRS_ZEROS)
                     && (hist_r[g+2*W-1 -: W] == vft_pkg::VFT_TRS_ZEROS)
                     && hist_r[g+vft_pkg::VFT_TW_ONE];
    end
  endgenerate

  // priority pick; two hits in one cycle cannot both be legal sequences
  always_comb begin
    off_nxt = '0;
    for (int i = W-1; i >= 0; i--) begin
      if (hits[i]) begin
        off_nxt = 4'(i);
      end
    end
  end

  // registered result and realigned word
  always_ff @(posedge clock) begin
    if (!resetn) begin
      trs.hit     <= 1'b0;
      trs.hit_off <= '0;
      trs.tword   <= '0;
      trs.word    <= '0;
    end else begin
      trs.hit     <= |hits;
      trs.hit_off <= off_nxt;
      trs.tword   <= hist_r[off_nxt +: W];
      trs.word    <= hist_r[trs.align +: W];
    end
  end

endmodule

/* core/vft_top.sv */
/*
  vft_top: word framing on timing reference sequences, raster format
  detection and confinement, timing bit status, APB register slave.
  assumes: runs on the recovered word clock; raw words come from the
  deserialiser on that same clock; APB master on that clock as well.
*/
// Decided for this implementation: register access over APB.
// Overview of operation
// - forced code admits only that one format
// - code bit 4 marks HD formats
// - code bit 3 marks 625 family, 1080 24p included
// - SD codes 01,02,03 and 09,0a,0b
// - HD codes 11,12,13,19,1a,1c,1d,14
// - high family lock alone confines search to HD
// - standard family lock alone confines search to SD
// - both clear searches all rates
// - style and permit clear: align once, keep
// - off-boundary sequence sets flag until aligned one
// - style one: flag acts as realign permit
// - style zero, permit one: realign every sequence
// - framing style resets to one
// - detected format reported in same code layout
// - 1.001 rate variants report same code
// - H, V, F from timing bits 6,7,8
// - H, V, F held for the field
`timescale 1ns/1ns
module vft_top #(
  parameter int W = 10                         // word width
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  // raw words from the deserialiser
  input  wire logic [W-1:0] raw_word,
  // framed words and events
  output logic [W-1:0]     video_word,
  output logic             trs_seen,
  output logic             new_sync_position_flag,
  // rate family search enables towards the frequency lock
  output logic             hd_search_en,
  output logic             sd_search_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  vft_trs_if trs ();                           // aligner link

  vft_pkg::vft_frm_e frm_r;                    // framing state
  vft_pkg::vft_frm_e frm_nxt;
  logic [3:0]   align_r;                       // word boundary in use
  logic [3:0]   align_nxt;
  logic         nsp_r;                         // new sync position flag
  logic         nsp_nxt;
  logic [9:0]   ctrl_r;                        // control register
  logic [31:0]  prdata_r;                      // read data, loaded at setup
  logic         pslverr_r;                     // error, loaded at setup
  logic         on_bound;                      // hit on current boundary
  logic         permit;                        // effective realign permit
  logic         eav;                           // aligned end-of-line mark
  logic [11:0]  wcnt_r;                        // words since last eav
  logic [11:0]  lcnt_r;                        // lines this frame
  logic [11:0]  acnt_r;                        // active lines this frame
  logic         sawf_r;                        // field bit seen this frame
  logic         vprev_r;                       // last seen vertical bit
  logic [11:0]  len_r;                         // words per line, measured
  logic [11:0]  lines_r;                       // lines per frame, measured
  logic [11:0]  act_r;                         // active lines, measured
  logic         intl_r;                        // interlaced, measured
  logic         frame_end;                     // vertical blanking starts, field 0
  logic [4:0]   cand;                          // raw classification
  logic [4:0]   fmt_r;                         // reported format
  logic [4:0]   fmt_nxt;
  logic [2:0]   hvf_r;                         // held timing bits
  logic         fprev_r;                       // field bit of held set
  logic         hvf_valid_r;                   // held set loaded once
  logic         wr_ctrl;                       // control register write
  logic         setup;                         // apb setup phase
  logic [4:0]   force_code;                    // forced format code
  logic         high_rate_family_lock;                       // high rate family lock
  logic         standard_rate_family_lock;                       // standard rate family lock

  // ----------------------------------------------------------------------
  // aligner
  // ----------------------------------------------------------------------
  vft_trs_align #(
    .W        (W)
  ) u_align (
    .clock    (clock),
    .resetn   (resetn),
    .raw_word (raw_word),
    .trs      (trs)
  );

  assign trs.align = align_r;

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  assign force_code = ctrl_r[vft_pkg::VFT_FMT_LSB +: vft_pkg::VFT_FMT_W];
  assign high_rate_family_lock    = ctrl_r[vft_pkg::VFT_HD_BIT];
  assign standard_rate_family_lock    = ctrl_r[vft_pkg::VFT_SD_BIT];

  // ----------------------------------------------------------------------
  // word framing
  // ----------------------------------------------------------------------
  assign on_bound = (trs.hit_off == align_r);

  // style one lets the flag act as the permit
  // style zero takes the permit bit as written
  // an external loop only works with style zero, so the bit passes as is
  assign permit = ctrl_r[vft_pkg::VFT_STYLE_BIT] ? nsp_r
                                                 : ctrl_r[vft_pkg::VFT_RLGN_BIT];

  // framing next state
  always_comb begin
    frm_nxt   = frm_r;
    align_nxt = align_r;
    nsp_nxt   = nsp_r;
    case (frm_r)
      vft_pkg::VFT_FRM_HUNT: begin
        // first valid sequence fixes the boundary
        if (trs.hit) begin
          frm_nxt   = vft_pkg::VFT_FRM_LOCK;
          align_nxt = trs.hit_off;
          nsp_nxt   = 1'b0;
        end
      end
      vft_pkg::VFT_FRM_LOCK: begin
        if (trs.hit && on_bound) begin
          nsp_nxt = 1'b0;
        end else if (trs.hit && permit) begin
          align_nxt = trs.hit_off;
          nsp_nxt   = 1'b0;
        end else if (trs.hit) begin
          // flag the off-boundary sequence, keep alignment
          nsp_nxt = 1'b1;
        end
      end
      default: begin
        frm_nxt   = vft_pkg::VFT_FRM_HUNT;
        align_nxt = '0;
        nsp_nxt   = 1'b0;
      end
    endcase
  end

  // framing registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      frm_r   <= vft_pkg::VFT_FRM_HUNT;
      align_r <= '0;
      nsp_r   <= 1'b0;
    end else begin
      frm_r   <= frm_nxt;
      align_r <= align_nxt;
      nsp_r   <= nsp_nxt;
    end
  end

  // sequence events only count once framed on the same boundary
  assign eav = trs.hit && on_bound && (frm_r == vft_pkg::VFT_FRM_LOCK)
             && trs.tword[vft_pkg::VFT_TW_H];

  // ----------------------------------------------------------------------
  // raster measurement
  // ----------------------------------------------------------------------
  // only word counts, line and active line counts and the field bit are measured, so a 1.001 rate
  // variant of the same raster lands on the same code
  assign frame_end = eav && trs.tword[vft_pkg::VFT_TW_V] && !vprev_r
                   && !trs.tword[vft_pkg::VFT_TW_F];

  // words per line
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wcnt_r <= '0;
      len_r  <= '0;
    end else if (eav) begin
      wcnt_r <= 12'h001;
      len_r  <= wcnt_r;
    end else if (wcnt_r != '1) begin
      wcnt_r <= wcnt_r + 12'h001;
    end
  end

  // lines, active lines and interlace per frame
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lcnt_r  <= '0;
      acnt_r  <= '0;
      sawf_r  <= 1'b0;
      vprev_r <= 1'b0;
      lines_r <= '0;
      act_r   <= '0;
      intl_r  <= 1'b0;
    end else if (frame_end) begin
      lcnt_r  <= 12'h001;
      acnt_r  <= '0;
      sawf_r  <= 1'b0;
      vprev_r <= 1'b1;
      lines_r <= lcnt_r;
      act_r   <= acnt_r;
      intl_r  <= sawf_r;
    end else if (eav) begin
      lcnt_r  <= lcnt_r + 12'h001;
      acnt_r  <= acnt_r + {11'h000, !trs.tword[vft_pkg::VFT_TW_V]};
      sawf_r  <= sawf_r | trs.tword[vft_pkg::VFT_TW_F];
      vprev_r <= trs.tword[vft_pkg::VFT_TW_V];
    end
  end

  // ----------------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------------
  // HD codes carry bit 4 set
  // 625 family bit 3 set, and 1080 24p too
  always_comb begin
    cand = vft_pkg::VFT_F_NONE;
    case (lines_r)
      vft_pkg::VFT_L525: begin
        if (len_r == vft_pkg::VFT_S3432) cand = vft_pkg::VFT_F_525_54;
        else if (len_r == vft_pkg::VFT_S2288) cand = vft_pkg::VFT_F_525_36;
        else if (len_r == vft_pkg::VFT_S1716) cand = vft_pkg::VFT_F_525_27;
      end
      vft_pkg::VFT_L625: begin
        if (len_r == vft_pkg::VFT_S3456) cand = vft_pkg::VFT_F_625_54;
        else if (len_r == vft_pkg::VFT_S2304) cand = vft_pkg::VFT_F_625_36;
        else if (len_r == vft_pkg::VFT_S1728) cand = vft_pkg::VFT_F_625_27;
      end
      // 1125 line codes, split by rate, scan and active lines
      vft_pkg::VFT_L1125: begin
        if (len_r == vft_pkg::VFT_S2200) begin
          if (!intl_r) cand = vft_pkg::VFT_F_1080P30;
          else if (act_r == vft_pkg::VFT_A1035) cand = vft_pkg::VFT_F_1035I;
          else cand = vft_pkg::VFT_F_1080I30;
        end else if (len_r == vft_pkg::VFT_S2640) begin
          cand = intl_r ? vft_pkg::VFT_F_1080I25 : vft_pkg::VFT_F_1080P25;
        end else if (len_r == vft_pkg::VFT_S2750) begin
          cand = vft_pkg::VFT_F_1080P24;
        end
      end
      vft_pkg::VFT_L1250: begin
        if (len_r == vft_pkg::VFT_S2376) cand = vft_pkg::VFT_F_1250I25;
      end
      vft_pkg::VFT_L750: begin
        if (len_r == vft_pkg::VFT_S1650) cand = vft_pkg::VFT_F_720P60;
      end
      default: begin
        cand = vft_pkg::VFT_F_NONE;
      end
    endcase
  end

  // confinement of what may be reported
  always_comb begin
    fmt_nxt = cand;
    if (force_code != vft_pkg::VFT_F_NONE) begin
      // a forced code admits that one format alone
      // the code is compared whole, never as a range
      if (cand != force_code) fmt_nxt = vft_pkg::VFT_F_NONE;
    end else if (high_rate_family_lock && !standard_rate_family_lock) begin
      if (!cand[vft_pkg::VFT_FMT_HD_BIT]) fmt_nxt = vft_pkg::VFT_F_NONE;
    end else if (standard_rate_family_lock && !high_rate_family_lock) begin
      if (cand[vft_pkg::VFT_FMT_HD_BIT]) fmt_nxt = vft_pkg::VFT_F_NONE;
    end
  end

  // detected format held in status, same code layout
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fmt_r <= vft_pkg::VFT_F_NONE;
    end else begin
      fmt_r <= fmt_nxt;
    end
  end

  // search enables toward the frequency lock
  always_comb begin
    if (force_code != vft_pkg::VFT_F_NONE) begin
      hd_search_en = force_code[vft_pkg::VFT_FMT_HD_BIT];
      sd_search_en = !force_code[vft_pkg::VFT_FMT_HD_BIT];
    end else begin
      // high family lock alone drops SD search
      // standard family lock alone drops HD search
      hd_search_en = high_rate_family_lock || !standard_rate_family_lock;
      sd_search_en = standard_rate_family_lock || !high_rate_family_lock;
    end
  end

  // ----------------------------------------------------------------------
  // timing bit status
  // ----------------------------------------------------------------------
  // H, V, F from timing word bits 6, 7, 8
  // reloaded on the first eav and when the field bit changes, held otherwise
  always_ff @(posedge clock) begin
    if (!resetn) begin
      hvf_r       <= '0;
      fprev_r     <= 1'b0;
      hvf_valid_r <= 1'b0;
    end else if (eav && (!hvf_valid_r
                 || (trs.tword[vft_pkg::VFT_TW_F] != fprev_r))) begin
      hvf_r       <= {trs.tword[vft_pkg::VFT_TW_F],
                      trs.tword[vft_pkg::VFT_TW_V],
                      trs.tword[vft_pkg::VFT_TW_H]};
      fprev_r     <= trs.tword[vft_pkg::VFT_TW_F];
      hvf_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // data outputs
  // ----------------------------------------------------------------------
  assign video_word             = trs.word;
  assign new_sync_position_flag = nsp_r;

  // one-cycle pulse on every aligned sequence
  always_ff @(posedge clock) begin
    if (!resetn) begin
      trs_seen <= 1'b0;
    end else begin
      trs_seen <= trs.hit && on_bound && (frm_r == vft_pkg::VFT_FRM_LOCK);
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // no wait states: read data is prepared in the setup phase
  assign setup   = psel && !penable;
  assign wr_ctrl = psel && penable && pwrite && (paddr == vft_pkg::VFT_CTRL_ADDR);
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_r <= vft_pkg::VFT_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[vft_pkg::VFT_REG_W-1:0];
    end
  end

  // read data and error, loaded at setup so they stand in the access phase
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
      if (paddr == vft_pkg::VFT_CTRL_ADDR) begin
        prdata_r[vft_pkg::VFT_REG_W-1:0] <= ctrl_r;
      end else if (paddr == vft_pkg::VFT_STAT_ADDR) begin
        // status is read only; a write is accepted and ignored
        prdata_r[vft_pkg::VFT_REG_W-1:0] <= {(frm_r == vft_pkg::VFT_FRM_LOCK),
                                            nsp_r, hvf_r, fmt_r};
      end else begin
        // unmapped: error, read zero
        pslverr_r <= 1'b1;
      end
    end
  end

endmodule

/* verification/vft_chk.sv */
/* vft_chk: port assertions on vft_top.
   assumes: bound into vft_top; one clock; resetn synchronous, low. */
`timescale 1ns/1ns
module vft_chk (
  input wire logic        clock, resetn, psel, penable, pwrite, pready, pslverr,
  input wire logic        trs_seen, new_sync_position_flag, hd_search_en, sd_search_en,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire stp = psel && !penable;                             // setup phase
  wire cwr = psel && penable && pwrite && paddr == 8'h2c;  // control write
  wire bad = paddr != 8'h2c && paddr != 8'h30;             // unmapped place
  wire unf = cwr && pwdata[4:0] == 5'h00;                  // write with no forced code
  a_zero_wait: assert property (psel && penable |-> pready) else $error("wait state");
  a_unmapped_err: assert property (stp && bad |=> pslverr && prdata == 0) else $error("no refusal");
  a_high_rate_family_lock: assert property (
    unf && pwdata[5] && !pwdata[6] |=> hd_search_en && !sd_search_en) else $error("high_rate_family_lock");
  a_standard_rate_family_lock: assert property (
    unf && pwdata[6] && !pwdata[5] |=> sd_search_en && !hd_search_en) else $error("standard_rate_family_lock");
  a_both_search: assert property (
    unf && !pwdata[5] && !pwdata[6] |=> hd_search_en && sd_search_en) else $error("search");
  a_reset_state: assert property (
    $rose(resetn) |-> hd_search_en && sd_search_en && !new_sync_position_flag) else $error("rst");
  // sequences are four words long, so boundary hits never crowd
  a_trs_gap: assert property (trs_seen |=> !trs_seen [*3]) else $error("hit gap");
  a_flag_excl: assert property (
    $rose(new_sync_position_flag) |-> !trs_seen) else $error("flag on hit");
  c_flag: cover property ($rose(new_sync_position_flag));
  c_trs: cover property (trs_seen);
  c_bad: cover property (stp && bad);
endmodule

/* verification/vft_src.sv */
/* vft_src: video source model, a sequence every 16 words, data between.
   assumes: off is the deserialiser's bit slip, tw the timing word. */
`timescale 1ns/1ns
module vft_src (
  input  wire logic       clock,
  input  wire logic [3:0] off,
  input  wire logic [9:0] tw,
  output logic [9:0]      raw_word
);
  logic [9:0] prev_r = 10'h000, cur_r = 10'h000;  // last two words sent
  logic [3:0] n_r = 4'h0;                         // word slot
  always_ff @(posedge clock) begin
    n_r <= n_r + 4'h1;
    prev_r <= cur_r;
    case (n_r)
      4'h0: cur_r <= 10'h3ff;
      4'h1, 4'h2: cur_r <= 10'h000;
      4'h3: cur_r <= tw;
      default: cur_r <= 10'($urandom_range(1019, 4));  // data never mimics a sequence
    endcase
  end
  assign raw_word = 10'({prev_r, cur_r} >> off);  // slip stream by off bits
endmodule

/* verification/tb.sv */
/* tb: self-checking bench for vft_top with the source model.
   assumes: vft_src and vft_chk compiled first. */
`timescale 1ns/1ns
module tb;
  logic        clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, w;
  logic        pready, pslverr, e, trs_seen, new_sync_position_flag, hd_search_en, sd_search_en;
  logic [9:0]  raw_word, video_word, raw_d1, raw_d2, tw = 10'h340;  // F=1, V=0, H=1
  logic [3:0]  off = 4'h0;                          // bit slip
  int          failures = 0, comparisons = 0, trs_n = 0;
  logic [4:0]  codes [14] = '{5'h01, 5'h02, 5'h03, 5'h09, 5'h0a, 5'h0b, 5'h11,
                              5'h12, 5'h13, 5'h19, 5'h1a, 5'h1c, 5'h1d, 5'h14};
  vft_src vft_src_i (.clock(clock), .off(off), .tw(tw), .raw_word(raw_word));
  vft_top vft_top_i (.*);
  initial forever #10 clock = ~clock;
  always @(posedge clock) trs_n <= trs_n + int'(trs_seen === 1'b1);
  // raw words two edges back, what an unslipped framed word must repeat
  always @(posedge clock) {raw_d2, raw_d1} <= {raw_d1, raw_word};
  // expected search enables: a forced code picks its own family, else the lock bits
  function automatic logic [1:0] srch(input logic [31:0] v);
    return (v[4:0] != 5'h00) ? {v[4], !v[4]} : {!v[6] | v[5], !v[5] | v[6]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // slip the source, settle, then judge flag and boundary hits
  task automatic frame(input logic [3:0] o, input logic [9:0] c, input logic f, input logic s);
    int n0;
    apb(1'b1, 8'h2c, {22'h0, c});
    off <= o;
    repeat (8) @(posedge clock);
    n0 = trs_n;
    repeat (72) @(posedge clock);
    chk(new_sync_position_flag, f);
    chk(trs_n > n0, s);
    if (o == 4'h0) chk(video_word, raw_d2);
    $display("frame test done, slip %0d", o);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hdf27_ee5c));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    apb(1'b0, 8'h2c, 32'h0);
    chk(q, 32'h0000_0080);
    apb(1'b0, 8'h00, 32'h0);
    chk({q[30:0], e}, 32'h1);
    // one code per write, every code once, each followed by an unforced write
    for (int i = 0; i < 28; i++) begin
      w = {23'h0, 2'($urandom), 2'(i / 2), (i[0] ? 5'h00 : codes[i / 2])};
      apb(1'b1, 8'h2c, w);
      apb(1'b0, 8'h2c, 32'h0);
      chk(q, w);
      chk({hd_search_en, sd_search_en}, srch(w));
    end
    $display("register test done");
    frame(4'h0, 10'h000, 1'b0, 1'b1);
    frame(4'h3, 10'h000, 1'b1, 1'b0);
    frame(4'h0, 10'h000, 1'b0, 1'b1);
    frame(4'h5, 10'h100, 1'b0, 1'b1);
    // the flag loop is modelled by style one; an external loop would need style zero
    frame(4'h9, 10'h080, 1'b0, 1'b1);
    apb(1'b0, 8'h30, 32'h0);
    chk(q[9:0], 10'h2a0);
    // field turns to F=0 with V=1, then V drops inside that field and must stay held
    tw <= 10'h2c0;
    repeat (40) @(posedge clock);
    tw <= 10'h240;
    repeat (40) @(posedge clock);
    apb(1'b0, 8'h30, 32'h0);
    chk(q[9:0], 10'h260);
    $display("status test done");
    complete_run();
  end
  // hang guard, far past the roughly 700 cycles needed
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    complete_run();
  end
endmodule
bind vft_top vft_chk vft_chk_i (.*);
